//--- rtl/viou_pkg.sv
/*
 * Shared constants and types for the video input/output unit.
 * Assumes a 32-bit classic Wishbone register bus and a byte-wide pixel stream.
 */
package viou_pkg;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_CC   = 8'h08;
    localparam logic [7:0] A_CAP  = 8'h0c;
    localparam logic [7:0] A_WSS  = 8'h10;
    localparam logic [7:0] A_GPIO = 8'h14;
    // Control field positions
    localparam int C_420  = 0;
    localparam int C_SEP  = 1;
    localparam int C_HSF  = 2;
    localparam int C_625  = 3;
    localparam int C_WID  = 4;
    localparam int C_HALF = 7;
    localparam int C_NRY  = 8;
    localparam int C_NRC  = 10;
    localparam int C_LOC  = 12;
    localparam int C_GPS  = 13;
    localparam int C_STOP = 14;
    localparam int C_ALL  = 15;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // Corrector window, clocks per line and lines per field
    localparam logic [11:0] L525_MIN = 12'd1626;
    localparam logic [11:0] L525_MAX = 12'd1806;
    localparam logic [11:0] L625_MIN = 12'd1628;
    localparam logic [11:0] L625_MAX = 12'd1828;
    localparam logic [9:0]  F525_MIN = 10'd246;
    localparam logic [9:0]  F525_MAX = 10'd278;
    localparam logic [9:0]  F625_MIN = 10'd294;
    localparam logic [9:0]  F625_MAX = 10'd330;
    // Blanking lines to slice, frame numbering
    localparam logic [9:0] CC_LN1  = 10'd20;
    localparam logic [9:0] CC_LN2  = 10'd283;
    localparam logic [9:0] CAP_LN1 = 10'd21;
    localparam logic [9:0] CAP_LN2 = 10'd284;
    localparam logic [9:0] WSS_LN1 = 10'd23;
    localparam logic [9:0] WSS_LN2 = 10'd336;
    localparam logic [9:0] F2_525  = 10'd263;
    localparam logic [9:0] F2_625  = 10'd313;
    // Pixel-clock counts; VS_OUT is in lines, W_FULL in pixels
    localparam logic [1:0]  PAR_DLY  = 2'd2;
    localparam logic [2:0]  SYNC_MIN = 3'd3;
    localparam logic [2:0]  VS_DLY   = 3'd4;
    localparam logic [11:0] ACT_B    = 12'd1440;
    localparam logic [11:0] HS_OUT   = 12'd128;
    localparam logic [9:0]  VS_OUT   = 10'd3;
    localparam logic [10:0] W_FULL   = 11'd720;

    typedef struct packed {
        logic       luma;
        logic       cr;
        logic [7:0] data;
    } viou_sample_t;

    typedef struct packed {
        logic [15:0]  ctrl;
        logic         err, evt, ack, ck, hs, vs, lok, fok, act, odd, keep, ohs, ovs, oclk, ev, ga, gb;
        logic [31:0]  cc, cap, wss, slc, rd;
        logic [6:0]   go;
        logic [4:0]   gn;
        logic [23:0]  sh;
        logic [1:0]   ph, pc;
        logic [11:0]  hc, hl;
        logic [9:0]   lc, acc;
        logic [2:0]   hw, vw, vd;
        logic [5:0]   sb;
        logic [7:0]   yp, bp, rp, op;
        viou_sample_t es;
    } viou_state_t;

    localparam viou_state_t ST_RST = '{gn: 5'h1f, default: '0};
endpackage

//--- rtl/viou_top.sv
/*
 * Video input/output unit: pixel capture, sync checking, field parity,
 * 4:2:0 conversion, width scaling, noise reduction, blanking slicer,
 * BT.656 output and general-purpose pins, behind a classic Wishbone slave.
 * Assumes pixel-side pins are asynchronous to clk_sys and that clk_sys runs
 * well above twice the pixel clock so every pixel edge is seen.
 */
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/100ps

module viou_top #(
    parameter logic [7:0] SLICE_THRESH = 8'h80,
    parameter logic [5:0] SLICE_SPB    = 6'd27
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output      logic [31:0]           wb_dat_o,
    output      logic                  wb_ack_o,
    input  wire logic [7:0]            in_pixel_bus,
    input  wire logic                  in_pixel_clock,
    input  wire logic                  in_hsync,
    input  wire logic                  in_vsync,
    input  wire logic                  in_field_flag,
    input  wire logic [7:0]            dec_pixel_bus,
    output      logic                  enc_valid,
    output      viou_pkg::viou_sample_t enc_sample,
    output      logic [7:0]            out_pixel_bus,
    output      logic                  out_pixel_clock,
    output      logic                  general_out_a,
    output      logic                  general_out_b,
    input  wire logic [4:0]            gpio_in,
    output      logic [4:0]            gpio_out,
    output      logic [4:0]            gpio_oe_n,
    output      logic                  sync_err_event
);
    import viou_pkg::*;

    viou_state_t s;
    viou_state_t n;
    logic [16:0] s1, s2, s3, sv;

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] bm(input logic [31:0] o, input logic [31:0] d, input logic [3:0] m);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Encoded width for the scaler
    function automatic logic [10:0] wsel(input logic [2:0] c);
        case (c)
            3'd0:    return 11'd720;
            3'd1:    return 11'd704;
            3'd2:    return 11'd544;
            3'd3:    return 11'd480;
            default: return 11'd352;
        endcase
    endfunction

    // Three-stage pin capture; a bit moves only when stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sv <= '0;
        end else begin
            s1 <= {gpio_in, in_field_flag, in_vsync, in_hsync, in_pixel_clock, in_pixel_bus};
            s2 <= s1;
            s3 <= s2;
            sv <= (sv & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
        end
    end

    logic        tick, ls, fs, set, clr, lum, crs, kn, sep;
    logic [7:0]  b, p, f;
    logic [1:0]  lvl;
    logic [10:0] sum;
    logic [9:0]  fl;
    logic [8:0]  d;
    logic [8:0]  dsh;
    logic [31:0] wd;

    // Next-state logic for bus, video path and pins
    always_comb begin
        n     = s;
        n.ack = 1'b0;
        n.ev  = 1'b0;
        n.evt = 1'b0;
        n.ck  = sv[8];
        n.oclk = sv[8];
        tick  = sv[8] & ~s.ck;
        b     = sv[7:0];
        sep   = s.ctrl[C_SEP];
        ls    = 1'b0;
        fs    = 1'b0;
        set   = 1'b0;
        clr   = 1'b0;
        lum   = s.ph[0];
        crs   = (s.ph == 2'd2);
        sum   = 11'({1'b0, s.acc}) + wsel(s.ctrl[C_WID +: 3]);
        kn    = (s.ph == 2'd0) ? (sum >= W_FULL) : s.keep;
        lvl   = lum ? s.ctrl[C_NRY +: 2] : s.ctrl[C_NRC +: 2];
        p     = lum ? s.yp : (crs ? s.rp : s.bp);
        d     = {1'b0, b} - {1'b0, p};
        dsh   = 9'($signed(d) >>> lvl);
        f     = p + dsh[7:0];
        fl    = s.odd ? s.lc : s.lc + (s.ctrl[C_625] ? F2_625 : F2_525);
        wd    = wb_dat_i;

        // Classic slave: one wait state, ack drops the cycle after
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            n.ack = 1'b1;
            case (wb_adr_i)
                A_CTRL:  n.rd = {16'h0000, s.ctrl};
                A_STAT:  n.rd = {s.lc, s.hl, 8'h00, s.odd, s.err};
                A_CC:    n.rd = s.cc;
                A_CAP:   n.rd = s.cap;
                A_WSS:   n.rd = s.wss;
                A_GPIO:  n.rd = {15'h0000, sv[16:12], ~s.gn, s.go};
                default: n.rd = 32'h0000_0000;
            endcase
            if (wb_we_i) begin
                case (wb_adr_i)
                    A_CTRL: begin
                        wd = bm({16'h0000, s.ctrl}, wb_dat_i, wb_sel_i);
                        n.ctrl = wd[15:0];
                        if (wd[C_ALL]) begin
                            n.ctrl = CTRL_RST;
                            n.go   = '0;
                            n.gn   = '1;
                        end
                    end
                    A_STAT:  clr = wb_dat_i[0] & wb_sel_i[0];
                    A_CC:    n.cc = bm(s.cc, wb_dat_i, wb_sel_i);
                    A_WSS:   n.wss = bm(s.wss, wb_dat_i, wb_sel_i);
                    A_GPIO: begin
                        wd = bm({20'h00000, ~s.gn, s.go}, wb_dat_i, wb_sel_i);
                        n.go = wd[6:0];
                        n.gn = ~wd[11:7];
                    end
                    default: ;
                endcase
            end
        end

        if (tick) begin
            n.sh = {s.sh[15:0], b};
            n.op = s.ctrl[C_LOC] ? dec_pixel_bus : b;
            n.hc = (s.hc != 12'hfff) ? s.hc + 12'd1 : s.hc;
            n.hs = sv[9];
            n.vs = sv[10];
            // Active samples: Cb,Y,Cr,Y repeating from each line start
            if (s.act && s.hc < ACT_B) begin
                n.ph = s.ph + 2'd1;
                if (s.ph == 2'd0) begin
                    n.keep = sum >= W_FULL;
                    n.acc  = (sum >= W_FULL) ? 10'(sum - W_FULL) : sum[9:0];
                end
                if (lum) begin
                    n.yp = f;
                end else if (crs) begin
                    n.rp = f;
                end else begin
                    n.bp = f;
                end
                // Chroma only on odd lines; covers both input formats
                n.ev = kn && !s.ctrl[C_STOP] && !(!lum && !s.lc[0])
                       && !(s.ctrl[C_HALF] && !s.odd);
                n.es = '{luma: lum, cr: crs, data: f};
                if (lum) begin
                    n.sb = (s.sb == SLICE_SPB - 6'd1) ? 6'd0 : s.sb + 6'd1;
                    if (s.sb == SLICE_SPB - 6'd1) begin
                        n.slc = {s.slc[30:0], b >= SLICE_THRESH};
                    end
                end
            end
            if (!sep) begin
                // Embedded codes: ff 00 00 then status byte
                if (s.sh == 24'hff0000) begin
                    if (!b[4]) begin
                        ls    = 1'b1;
                        n.act = !b[5];
                    end else begin
                        n.act = 1'b0;
                        fs    = (~b[6]) != s.odd;
                        n.odd = ~b[6];
                    end
                end
            end else begin
                ls    = sv[9] & ~s.hs;
                fs    = ~sv[10] & s.vs;
                n.act = 1'b1;
                // Pulse width watch: each level must last more than three ticks
                n.hw = (sv[9] != s.hs) ? 3'd0 : ((s.hw != 3'd7) ? s.hw + 3'd1 : s.hw);
                n.vw = (sv[10] != s.vs) ? 3'd0 : ((s.vw != 3'd7) ? s.vw + 3'd1 : s.vw);
                if (s.lok && ((sv[9] != s.hs && s.hw < SYNC_MIN) || (sv[10] != s.vs && s.vw < SYNC_MIN))) begin
                    set = 1'b1;
                end
                if (fs) begin
                    if (s.ctrl[C_HSF]) begin
                        n.pc = PAR_DLY;
                    end else begin
                        n.odd = sv[11];
                    end
                end
                if (s.pc != 2'd0) begin
                    if (s.pc == 2'd1) begin
                        n.odd = sv[9];
                    end
                    n.pc = s.pc - 2'd1;
                end
            end
            if (ls) begin
                // Line length outside the corrector window
                if (s.lok && (s.ctrl[C_625] ? (s.hc < L625_MIN || s.hc > L625_MAX)
                                            : (s.hc < L525_MIN || s.hc > L525_MAX))) begin
                    set = 1'b1;
                end
                // Captured slice only kept while encoding runs
                if (!s.ctrl[C_STOP]) begin
                    if (!s.ctrl[C_625] && (fl == CC_LN1 || fl == CC_LN2)) begin
                        n.cc = s.slc;
                    end
                    if (!s.ctrl[C_625] && (fl == CAP_LN1 || fl == CAP_LN2)) begin
                        n.cap = s.slc;
                    end
                    if (s.ctrl[C_625] && (fl == WSS_LN1 || fl == WSS_LN2)) begin
                        n.wss = s.slc;
                    end
                end
                n.lok = 1'b1;
                n.hl  = s.hc;
                n.hc  = 12'd0;
                n.lc  = s.lc + 10'd1;
                n.ph  = 2'd0;
                n.acc = 10'd0;
                n.sb  = 6'd0;
                n.slc = 32'h0000_0000;
                n.vd  = VS_DLY;
            end else if (s.vd != 3'd0) begin
                if (s.vd == 3'd1) begin
                    n.ovs = s.lc <= VS_OUT;
                end
                n.vd = s.vd - 3'd1;
            end
            if (fs) begin
                if (s.fok && (s.ctrl[C_625] ? (s.lc < F625_MIN || s.lc > F625_MAX)
                                            : (s.lc < F525_MIN || s.lc > F525_MAX))) begin
                    set = 1'b1;
                end
                n.fok = 1'b1;
                n.lc  = 10'd0;
            end
            n.ohs = n.hc < HS_OUT;
        end

        // Set beats a same-cycle clear so no error is lost
        n.err = (s.err & ~clr) | set;
        n.evt = set & ~s.err;
        n.ga  = s.ctrl[C_GPS] ? s.ohs : s.go[5];
        n.gb  = s.ctrl[C_GPS] ? s.ovs : s.go[6];
    end

    // Pins come up as inputs; state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state flops
    assign wb_dat_o        = s.rd;
    assign wb_ack_o        = s.ack;
    assign enc_valid       = s.ev;
    assign enc_sample      = s.es;
    assign out_pixel_bus   = s.op;
    assign out_pixel_clock = s.oclk;
    assign general_out_a   = s.ga;
    assign general_out_b   = s.gb;
    assign gpio_out        = s.go[4:0];
    assign gpio_oe_n       = s.gn;
    assign sync_err_event  = s.evt;
endmodule

//--- sim/viou_monitor.sv
/* Checker bound to the video unit top: bus handshake, pin reset, pulse shapes.
   Assumes one clk_sys domain with synchronous active-high rst. */
`timescale 1ns/100ps
module viou_monitor
    import viou_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        enc_valid,
    input wire logic [4:0]  gpio_out,
    input wire logic [4:0]  gpio_oe_n,
    input wire logic        sync_err_event
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Request taken, and the full-reset write among them
    sequence wb_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence all_rst_wr; wb_take ##0 (wb_we_i && wb_adr_i == A_CTRL && wb_dat_i[C_ALL]); endsequence
    ack_after_take_a: assert property (wb_take |=> wb_ack_o) else $error("no ack after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
    unmapped_zero_a: assert property (wb_take ##0 (!wb_we_i && wb_adr_i > A_GPIO) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    full_reset_pins_a: assert property (all_rst_wr |=> gpio_oe_n == 5'h1f && gpio_out == 5'h00)
        else $error("pins not inputs after full reset");
    hw_reset_pins_a: assert property (@(posedge clk_sys) disable iff (1'b0) rst |=> gpio_oe_n == 5'h1f)
        else $error("pins not inputs in reset");
    pin_dir_cause_a: assert property ($changed(gpio_oe_n) |-> wb_ack_o || $past(rst))
        else $error("pin direction moved without a write");
    err_event_once_a: assert property (sync_err_event |=> !sync_err_event) else $error("error event repeated");
    enc_pulse_a: assert property (enc_valid |=> !enc_valid [*2]) else $error("sample strobe too long");
endmodule

bind viou_top viou_monitor i_monitor (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .enc_valid(enc_valid), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .sync_err_event(sync_err_event));

//--- sim/viou_src.sv
/* Video source model with separate syncs and random pixel bytes.
   Assumes the bench calls send_line per line; pixel clock runs only meanwhile. */
`timescale 1ns/100ps
module viou_src (
    output logic       in_pixel_clock,
    output logic [7:0] in_pixel_bus,
    output logic       in_hsync,
    output logic       in_vsync,
    output logic       in_field_flag
);
    localparam int LINE_TICKS = 1716; // Inside both corrector windows
    int pos = 0; // Byte index within the line, read by the bench
    initial begin
        in_pixel_clock = 1'b0;
        in_pixel_bus = 8'h00;
        in_hsync = 1'b0;
        in_vsync = 1'b0;
        in_field_flag = 1'b0;
    end
    // One line; levels change on the falling pixel edge
    task automatic send_line(input int hs_len, input int vs_rise, input int vs_fall);
        for (int t = 0; t < LINE_TICKS; t++) begin
            in_hsync = (t < hs_len);
            in_field_flag = (t >= hs_len); // Wrong source would give wrong parity
            if (t == vs_rise) in_vsync = 1'b1;
            if (t == vs_fall) in_vsync = 1'b0;
            in_pixel_bus = 8'($urandom);
            pos = t;
            #160 in_pixel_clock = 1'b1;
            #160 in_pixel_clock = 1'b0;
        end
        in_pixel_bus = ~in_pixel_bus; // Idle bus shows no stale byte
    endtask
endmodule

//--- sim/video_input_output_unit_tb.sv
/* Bench for the video unit: registers, general pins, parity, sync errors, sync outputs.
   Assumes viou_src drives the pixel pins and viou_monitor is bound to the top. */
`timescale 1ns/100ps
module video_input_output_unit_tb;
    import viou_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]   wb_adr_i = 8'h00, dec_pixel_bus = 8'h00, in_pixel_bus, out_pixel_bus;
    logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, rd, w;
    logic         wb_ack_o, in_pixel_clock, in_hsync, in_vsync, in_field_flag, enc_valid, out_pixel_clock;
    logic         general_out_a, general_out_b, sync_err_event, gps_on = 1'b0, ga_q = 1'b0, gb_q = 1'b0;
    logic [4:0]   gpio_in, gpio_out, gpio_oe_n;
    viou_sample_t enc_sample;
    logic [7:0]   slice_adr [3] = '{A_CC, A_WSS, A_CAP};
    int           err_total = 0, num_checks = 0, ev_cnt = 0, hs_cnt = 0;
    logic [7:0]   pix_q = 8'h00, dec_h = 8'h00;
    logic         opc_q = 1'b0, loc_on = 1'b0;
    int           pos_q = 0, luma_cnt = 0, chroma_cnt = 0;

    always #20 clk_sys = ~clk_sys;
    assign gpio_in = gpio_out | gpio_oe_n; // Pull-ups win where the unit does not drive
    viou_top i_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .in_pixel_bus(in_pixel_bus), .in_pixel_clock(in_pixel_clock), .in_hsync(in_hsync), .in_vsync(in_vsync),
        .in_field_flag(in_field_flag), .dec_pixel_bus(dec_pixel_bus), .enc_valid(enc_valid),
        .enc_sample(enc_sample), .out_pixel_bus(out_pixel_bus), .out_pixel_clock(out_pixel_clock),
        .general_out_a(general_out_a), .general_out_b(general_out_b), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .sync_err_event(sync_err_event));
    viou_src i_src (.in_pixel_clock(in_pixel_clock), .in_pixel_bus(in_pixel_bus), .in_hsync(in_hsync),
        .in_vsync(in_vsync), .in_field_flag(in_field_flag));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack, take data at that edge, then release
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        // No assumed latency: only the watchdog ends a wait
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Pin levels seen back: driven bits, else pulled high
    function automatic logic [31:0] gpio_exp(input logic [31:0] v);
        return {15'h0, v[4:0] | ~v[11:7], v[11:0]};
    endfunction
    // Expected encoder sample: Cb,Y,Cr,Y from the first byte after the hsync rise
    function automatic logic [9:0] enc_exp(input int pos, input logic [7:0] d);
        return {pos[0] == 1'b0, pos[1:0] == 2'd3, d};
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) dec_pixel_bus <= 8'($urandom);
    always @(posedge clk_sys) if (sync_err_event === 1'b1) ev_cnt++;
    // Byte and its line position at each pixel rise
    always @(posedge in_pixel_clock) begin
        pix_q <= in_pixel_bus;
        pos_q <= i_src.pos;
    end
    // Pixel path seen one clock after each filtered tick; noise reduction off, so bytes pass unchanged
    always @(posedge clk_sys) begin
        dec_h <= dec_pixel_bus;
        opc_q <= out_pixel_clock;
        if (out_pixel_clock && !opc_q) check({24'h0, out_pixel_bus}, {24'h0, loc_on ? dec_h : pix_q});
        if (enc_valid === 1'b1) begin
            check({22'h0, enc_sample}, {22'h0, enc_exp(pos_q, pix_q)});
            luma_cnt += enc_sample.luma;
            chroma_cnt += !enc_sample.luma;
        end
    end
    // Sync outputs timed from the hsync rise, 8 clocks per pixel tick
    always @(posedge clk_sys) begin
        hs_cnt = (general_out_a && !ga_q) ? 0 : hs_cnt + 1;
        if (gps_on && !general_out_a && ga_q) check(hs_cnt, 32'(HS_OUT) * 8);
        if (gps_on && general_out_b !== gb_q) check(hs_cnt, 32'(VS_DLY) * 8);
        ga_q = general_out_a;
        gb_q = general_out_b;
    end
    initial begin
        #3600000;
        check(32'h1, 32'h0); // Hung run counts as a mismatch
        conclude();
    end
    initial begin
        void'($urandom(32'h7e4f));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({27'h0, gpio_oe_n}, 32'h1f);
        wb_cycle(1'b0, A_CTRL, 32'h0, rd);
        check(rd, {16'h0, CTRL_RST});
        wb_cycle(1'b0, 8'h20, 32'h0, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 3; i++) begin
            w = (i == 2) ? 32'h0fff : ($urandom & 32'h0fff);
            wb_cycle(1'b1, A_GPIO, w, rd);
            repeat (4) @(posedge clk_sys);
            wb_cycle(1'b0, A_GPIO, 32'h0, rd);
            check(rd, gpio_exp(w));
            check({27'h0, gpio_oe_n}, {27'h0, ~w[11:7]});
            check({30'h0, general_out_b, general_out_a}, {30'h0, w[6:5]});
        end
        wb_cycle(1'b1, A_CTRL, 32'h8000, rd);
        repeat (4) @(posedge clk_sys);
        wb_cycle(1'b0, A_GPIO, 32'h0, rd);
        check(rd, gpio_exp(32'h0));
        wb_cycle(1'b0, A_CTRL, 32'h0, rd);
        check(rd, 32'h0);
        foreach (slice_adr[i]) begin
            w = $urandom;
            wb_cycle(1'b1, slice_adr[i], w, rd);
            wb_cycle(1'b0, slice_adr[i], 32'h0, rd);
            check(rd, (i == 2) ? 32'h0 : w);
        end
        wb_cycle(1'b1, A_CTRL, 32'h2006, rd);
        gps_on <= 1'b1;
        #13;
        i_src.send_line(64, -1, -1);
        i_src.send_line(64, 10, -1);
        i_src.send_line(64, -1, 2);
        wb_cycle(1'b0, A_STAT, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h2);
        wb_cycle(1'b1, A_CTRL, 32'h3006, rd);
        loc_on <= 1'b1;
        #13;
        i_src.send_line(64, 10, -1);
        i_src.send_line(64, -1, 200);
        repeat (8) @(posedge clk_sys);
        wb_cycle(1'b0, A_STAT, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h1);
        wb_cycle(1'b1, A_STAT, 32'h1, rd);
        wb_cycle(1'b0, A_STAT, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h0);
        check(ev_cnt, 32'h1);
        check(luma_cnt, 32'(W_FULL) * 5);
        check(chroma_cnt, 32'(W_FULL) * 2 + 1); // odd lines 1 and 4, plus one Cb before the flip
        conclude();
    end
endmodule
